// >>> common/eeprom_pkg.sv
// constants and types shared by the serial memory access logic
package eeprom_pkg;

   // ----------------------------------------------------------------
   // array geometry
   // ----------------------------------------------------------------
   localparam int ADDR_W = 15;
   localparam int MEM_BYTES = 32768;
   localparam int PAGE_BITS = 6;
   localparam int PAGE_BYTES = 64;
   localparam int PAGE_NUM_W = ADDR_W - PAGE_BITS;
   localparam int HI_ADDR_BITS = 7;
   localparam int BYTE_W = 8;

   localparam logic [14:0] PROT_BASE = 15'h7000;
   localparam logic [14:0] TOP_ADDR = 15'h7FFF;
   localparam logic [14:0] MFR_ADDR = 15'h7FFA;
   localparam logic [14:0] DEV_ADDR = 15'h7FFB;
   localparam logic [14:0] SER_ADDR = 15'h7FFC;

   // ----------------------------------------------------------------
   // control byte
   // ----------------------------------------------------------------
   localparam logic [3:0] CTRL_CODE = 4'hA;
   localparam int CODE_MSB = 7;
   localparam int CODE_LSB = 4;
   localparam int SEL_MSB = 3;
   localparam int SEL_LSB = 1;
   localparam int RW_BIT = 0;

   // ----------------------------------------------------------------
   // bit counter marks within one nine-clock frame
   // ----------------------------------------------------------------
   localparam logic [3:0] ACK_SLOT = 4'h8;
   localparam logic [3:0] ACK_DONE = 4'h9;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int WRITE_TIME_NS = 5000000;
   localparam int WRITE_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      st_idle,
      st_ctrl,
      st_addr_hi,
      st_addr_lo,
      st_wdata,
      st_rdata
   } state_t;

endpackage : eeprom_pkg

// >>> logic/eeprom_access.sv
// two-wire serial memory slave: command decode, page buffer, array, reads
//
// Behaviour
// R1: control byte is code 1010, three select bits matching pins, then read/write.
// R2: word address is two bytes, high first; only low fifteen bits are kept.
// R3: sequential reads stay inside this device; select bits may extend address (here they are only compared with the pins).
// R4: byte write is control, high address, low address, data, each acknowledged.
// R5: Stop after write data starts timed write; no acknowledges while it runs.
// R6: untouched bytes of a partly written page are rewritten with old contents.
// R7: page write buffers first byte plus up to 63 more; commit after Stop.
// R8: only low six pointer bits advance per written byte, wrapping in page.
// R9: master keeps every page write inside a single physical page.
// R10: writes to the upper protected range are blocked; reads work normally.
// R11: lower range from zero to last unprotected address reads and writes normally.
// R12: protected-range writes are acknowledged as usual but change nothing.
// R13: write control byte gets no acknowledge until the write cycle ends.
// R14: master repeats Start and control byte until acknowledged.
// R15: current address read returns the byte one past the last accessed.
// R16: master not-acknowledge then Stop ends a read; device releases data.
// R17: address phase then repeated Start loads pointer without any write.
// R18: after a random read the pointer holds the next location.
// R19: each master acknowledge during a read fetches the next byte.
// R20: read pointer wraps from top address to zero.
// R21: serial number sits in the four highest array locations, protected.
// R22: maker code and device identifier sit just below the serial number.
`timescale 1ns/1ps
module eeprom_access #(
   parameter int unsigned WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES,
   // identity values below are arbitrary
   parameter logic [7:0] MFR_CODE = 8'h5A,
   parameter logic [3:0] ID_FAMILY = 4'h3,
   parameter logic [3:0] ID_DENSITY = 4'h7,
   parameter logic [3:0][7:0] SERIAL_NUMBER = 32'hA5C3_0F01
) (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic chip_select_bit0_i,
   input wire logic chip_select_bit1_i,
   input wire logic chip_select_bit2_i,
   output logic sda_o,
   output logic sda_oe_o,
   output logic write_busy_o
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      eeprom_pkg::state_t st;
      logic [3:0] bit_cnt;
      logic [7:0] shift;
      logic [7:0] rbyte;
      logic [eeprom_pkg::ADDR_W-1:0] ptr;
      logic [eeprom_pkg::PAGE_NUM_W-1:0] page;
      logic [eeprom_pkg::PAGE_BYTES-1:0] valid;
      logic [eeprom_pkg::PAGE_BITS-1:0] cidx;
      logic rw;
      logic mack;
      logic wr_pend;
      logic commit;
      logic tmr_go;
      logic scl_d;
      logic sda_d;
      logic sda_out;
      logic sda_oe;
   } core_t;

   core_t s_q;
   core_t s_d;

   logic [7:0] mem [0:eeprom_pkg::MEM_BYTES-1];
   logic [7:0] pbuf [0:eeprom_pkg::PAGE_BYTES-1];

   logic mem_we;
   logic [eeprom_pkg::ADDR_W-1:0] mem_wa;
   logic [7:0] mem_wd;
   logic pb_we;
   logic [eeprom_pkg::PAGE_BITS-1:0] pb_idx;
   logic [7:0] pb_wd;
   logic [7:0] fetch_byte;

   // ----------------------------------------------------------------
   // pin synchronisation and bus conditions
   // ----------------------------------------------------------------
   logic [4:0] pins_s;
   logic scl_s;
   logic sda_s;
   logic [2:0] sel_s;
   logic tmr_busy;

   pin_sync #(
      .WIDTH(5)
   ) u_sync (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .pin_i({chip_select_bit2_i, chip_select_bit1_i, chip_select_bit0_i, sda_i, scl_i}),
      .sync_o(pins_s)
   );

   assign scl_s = pins_s[0];
   assign sda_s = pins_s[1];
   assign sel_s = pins_s[4:2];

   write_timer #(
      .CYCLES(WRITE_CYCLES)
   ) u_timer (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .go_i(s_q.tmr_go),
      .busy_o(tmr_busy)
   );

   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   logic busy;
   logic ctrl_match;

   assign scl_rise = scl_s & ~s_q.scl_d;
   assign scl_fall = ~scl_s & s_q.scl_d;
   assign bus_start = scl_s & s_q.scl_d & s_q.sda_d & ~sda_s;
   assign bus_stop = scl_s & s_q.scl_d & ~s_q.sda_d & sda_s;
   assign busy = tmr_busy | s_q.commit | s_q.tmr_go;

   assign ctrl_match =
      (s_q.shift[eeprom_pkg::CODE_MSB:eeprom_pkg::CODE_LSB] == eeprom_pkg::CTRL_CODE)
      && (s_q.shift[eeprom_pkg::SEL_MSB:eeprom_pkg::SEL_LSB] == sel_s); // [R1] [R3]

   // ----------------------------------------------------------------
   // read source: fixed identity bytes above the array contents
   // ----------------------------------------------------------------
   always_comb begin
      if (s_q.ptr >= eeprom_pkg::SER_ADDR) begin
         fetch_byte = SERIAL_NUMBER[~s_q.ptr[1:0]]; // [R21]
      end else if (s_q.ptr == eeprom_pkg::DEV_ADDR) begin
         fetch_byte = {ID_FAMILY, ID_DENSITY}; // [R22]
      end else if (s_q.ptr == eeprom_pkg::MFR_ADDR) begin
         fetch_byte = MFR_CODE; // [R22]
      end else begin
         fetch_byte = mem[s_q.ptr]; // [R10] [R11]
      end
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   logic [eeprom_pkg::ADDR_W-1:0] commit_addr;
   logic [2:0] tx_idx;

   always_comb begin
      s_d = s_q;
      s_d.scl_d = scl_s;
      s_d.sda_d = sda_s;
      s_d.tmr_go = 1'b0;
      s_d.sda_out = 1'b0;
      mem_we = 1'b0;
      mem_wa = '0;
      mem_wd = '0;
      pb_we = 1'b0;
      pb_idx = s_q.ptr[eeprom_pkg::PAGE_BITS-1:0];
      pb_wd = s_q.shift;
      commit_addr = {s_q.page, s_q.cidx};
      tx_idx = 3'h7 - s_q.bit_cnt[2:0];

      // page commit: walk the whole page, new bytes where buffered, old ones elsewhere
      if (s_q.commit) begin
         mem_wa = commit_addr;
         mem_wd = s_q.valid[s_q.cidx] ? pbuf[s_q.cidx] : mem[commit_addr]; // [R6]
         mem_we = (commit_addr < eeprom_pkg::PROT_BASE); // [R10] [R11] [R12]
         s_d.cidx = s_q.cidx + 1'b1;
         if (&s_q.cidx) begin
            s_d.commit = 1'b0;
         end
      end

      if (bus_start) begin
         // repeated start abandons any buffered bytes without a write
         s_d.st = eeprom_pkg::st_ctrl;
         s_d.bit_cnt = '0;
         s_d.sda_oe = 1'b0;
         s_d.wr_pend = 1'b0; // [R17]
      end else if (bus_stop) begin
         if ((s_q.st == eeprom_pkg::st_wdata) && s_q.wr_pend) begin
            s_d.commit = 1'b1; // [R5] [R7]
            s_d.cidx = '0;
            s_d.page = s_q.ptr[eeprom_pkg::ADDR_W-1:eeprom_pkg::PAGE_BITS];
            s_d.tmr_go = 1'b1; // [R5]
         end
         s_d.st = eeprom_pkg::st_idle;
         s_d.sda_oe = 1'b0; // [R16]
         s_d.wr_pend = 1'b0;
      end else if (s_q.st != eeprom_pkg::st_idle) begin
         if (scl_rise) begin
            if (s_q.bit_cnt < eeprom_pkg::ACK_SLOT) begin
               s_d.shift = {s_q.shift[6:0], sda_s};
               s_d.bit_cnt = s_q.bit_cnt + 4'h1;
            end else begin
               s_d.mack = ~sda_s;
               s_d.bit_cnt = eeprom_pkg::ACK_DONE;
            end
         end else if (scl_fall) begin
            if (s_q.bit_cnt == eeprom_pkg::ACK_SLOT) begin
               // eight bits in: decide the acknowledge
               unique case (s_q.st)
                  eeprom_pkg::st_ctrl: begin
                     if (ctrl_match && !busy) begin
                        s_d.rw = s_q.shift[eeprom_pkg::RW_BIT];
                        s_d.sda_oe = 1'b1; // [R1] [R4] [R13]
                     end else begin
                        s_d.st = eeprom_pkg::st_idle; // [R5] [R13]
                     end
                  end
                  eeprom_pkg::st_addr_hi: begin
                     // top address bit is a don't care
                     s_d.ptr[eeprom_pkg::ADDR_W-1:eeprom_pkg::BYTE_W] =
                        s_q.shift[eeprom_pkg::HI_ADDR_BITS-1:0]; // [R2]
                     s_d.sda_oe = 1'b1; // [R4]
                     s_d.st = eeprom_pkg::st_addr_lo;
                  end
                  eeprom_pkg::st_addr_lo: begin
                     s_d.ptr[eeprom_pkg::BYTE_W-1:0] = s_q.shift; // [R2] [R17]
                     s_d.valid = '0;
                     s_d.sda_oe = 1'b1; // [R4]
                     s_d.st = eeprom_pkg::st_wdata;
                  end
                  eeprom_pkg::st_wdata: begin
                     pb_we = 1'b1; // [R7]
                     s_d.valid[pb_idx] = 1'b1;
                     s_d.wr_pend = 1'b1;
                     s_d.ptr[eeprom_pkg::PAGE_BITS-1:0] = pb_idx + 1'b1; // [R8]
                     s_d.sda_oe = 1'b1; // [R4] [R12]
                  end
                  eeprom_pkg::st_rdata: begin
                     s_d.sda_oe = 1'b0;
                  end
                  default: begin
                     s_d.st = eeprom_pkg::st_idle;
                  end
               endcase
            end else if (s_q.bit_cnt == eeprom_pkg::ACK_DONE) begin
               s_d.bit_cnt = '0;
               s_d.sda_oe = 1'b0;
               if (((s_q.st == eeprom_pkg::st_ctrl) && s_q.rw)
                   || ((s_q.st == eeprom_pkg::st_rdata) && s_q.mack)) begin
                  // load the byte at the pointer and step past it
                  s_d.rbyte = fetch_byte; // [R15] [R19]
                  s_d.ptr = s_q.ptr + 1'b1; // [R18] [R20] [R3]
                  s_d.sda_oe = ~fetch_byte[7];
                  s_d.st = eeprom_pkg::st_rdata;
               end else if (s_q.st == eeprom_pkg::st_ctrl) begin
                  s_d.st = eeprom_pkg::st_addr_hi; // [R4]
               end else if (s_q.st == eeprom_pkg::st_rdata) begin
                  s_d.st = eeprom_pkg::st_idle; // [R16]
               end
            end else if ((s_q.st == eeprom_pkg::st_rdata) && (s_q.bit_cnt != '0)) begin
               s_d.sda_oe = ~s_q.rbyte[tx_idx];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         s_q <= '0;
         s_q.scl_d <= 1'b1;
         s_q.sda_d <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (mem_we) begin
         mem[mem_wa] <= mem_wd;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (pb_we) begin
         pbuf[pb_idx] <= pb_wd;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   logic busy_q;

   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         busy_q <= 1'b0;
      end else begin
         busy_q <= busy;
      end
   end

   assign sda_o = s_q.sda_out;
   assign sda_oe_o = s_q.sda_oe;
   assign write_busy_o = busy_q;

endmodule : eeprom_access

// >>> logic/pin_sync.sv
// two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic [WIDTH-1:0] pin_i,
   output logic [WIDTH-1:0] sync_o
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sync_t;

   sync_t s_q;
   sync_t s_d;

   always_comb begin
      s_d.meta = pin_i;
      s_d.stable = s_q.meta;
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         s_q <= '1;
      end else begin
         s_q <= s_d;
      end
   end

   assign sync_o = s_q.stable;
endmodule : pin_sync

// >>> logic/write_timer.sv
// self-timed write cycle counter
`timescale 1ns/1ps
module write_timer #(
   parameter int unsigned CYCLES = eeprom_pkg::WRITE_CYCLES
) (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic go_i,
   output logic busy_o
);
   localparam int CNT_W = $clog2(CYCLES + 1);
   localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

   typedef struct packed {
      logic busy;
      logic [CNT_W-1:0] cnt;
   } tmr_t;

   tmr_t s_q;
   tmr_t s_d;

   always_comb begin
      s_d = s_q;
      if (go_i) begin
         s_d.busy = 1'b1;
         s_d.cnt = '0;
      end else if (s_q.busy) begin
         if (s_q.cnt == LAST) begin
            s_d.busy = 1'b0;
         end else begin
            s_d.cnt = s_q.cnt + CNT_W'(1);
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign busy_o = s_q.busy;
endmodule : write_timer

// >>> verif/eeprom_access_properties.sv
// pin-level checks for the serial memory access logic
`timescale 1ns/1ps
module eeprom_access_properties #(
   parameter int unsigned WRITE_CYCLES = 200
) (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic chip_select_bit0_i,
   input wire logic chip_select_bit1_i,
   input wire logic chip_select_bit2_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic write_busy_o
);
   logic scl_q, sda_q;
   logic [3:0] rises_q, since_stop_q;
   logic [31:0] busy_len_q;
   // ----------------------------------------------------------------
   // frame tracking on the raw pins
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      if (!rst_b_i) begin
         rises_q <= 4'h0;
         since_stop_q <= 4'hF;
         busy_len_q <= 32'h0;
      end else begin
         if (scl_i && scl_q && sda_q && !sda_i) begin
            rises_q <= 4'h0;
         end else if (scl_i && !scl_q && rises_q != 4'hF) begin
            rises_q <= rises_q + 4'h1;
         end
         if (scl_i && scl_q && !sda_q && sda_i) begin
            since_stop_q <= 4'h0;
         end else if (since_stop_q != 4'hF) begin
            since_stop_q <= since_stop_q + 4'h1;
         end
         busy_len_q <= write_busy_o ? busy_len_q + 32'h1 : 32'h0;
      end
   end
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   a_reset_quiet: assert property ($rose(rst_b_i) |-> !sda_oe_o && !write_busy_o)
      else $error("outputs active right after reset");
   a_open_drain: assert property (sda_o == 1'b0)
      else $error("data pin driven high");
   a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
      else $error("data drive changed while clock high");
   a_ctrl_first: assert property (sda_oe_o |-> rises_q >= 4'h8)
      else $error("drive before a whole control byte");
   a_busy_no_ack: assert property (write_busy_o && $past(write_busy_o) |-> !sda_oe_o)
      else $error("acknowledge during write cycle");
   a_busy_by_stop: assert property ($rose(write_busy_o) |-> since_stop_q < 4'hC)
      else $error("write cycle without a stop");
   a_busy_min: assert property ($fell(write_busy_o) |-> busy_len_q >= WRITE_CYCLES)
      else $error("write cycle too short");
   a_busy_max: assert property (busy_len_q <= WRITE_CYCLES + 32'd80)
      else $error("write cycle too long");
   c_write_done: cover property ($fell(write_busy_o));
   c_ack_given: cover property ($rose(sda_oe_o) && rises_q == 4'h8);
   c_read_bit: cover property ($rose(sda_oe_o) && rises_q > 4'h9);
endmodule : eeprom_access_properties

bind eeprom_access eeprom_access_properties #(.WRITE_CYCLES(WRITE_CYCLES)) chk_u (
   .mclk_i(mclk_i), .rst_b_i(rst_b_i), .scl_i(scl_i), .sda_i(sda_i),
   .chip_select_bit0_i(chip_select_bit0_i), .chip_select_bit1_i(chip_select_bit1_i),
   .chip_select_bit2_i(chip_select_bit2_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
   .write_busy_o(write_busy_o)
);

// >>> verif/i2c_master_model.sv
// bus master model driving the serial clock and the data wire
`timescale 1ns/1ps
module i2c_master_model (
   input wire logic dut_oe_i,
   output logic scl_o,
   output logic sda_o
);
   logic drv_low = 1'b0;
   initial scl_o = 1'b1;
   // open-drain wire with pull-up
   assign sda_o = !(drv_low || dut_oe_i);
   // steps are multiples of the system period, so callers entering on a
   // falling system edge stay on falling edges
   task automatic clk_bit(input logic b, output logic got);
      #400 drv_low = !b;
      #100 scl_o = 1'b1;
      #200 got = sda_o;
      #100 scl_o = 1'b0;
   endtask : clk_bit
   task automatic start();
      #400 drv_low = 1'b0;
      #100 scl_o = 1'b1;
      #300 drv_low = 1'b1;
      #400 scl_o = 1'b0;
   endtask : start
   // clock then stands still high between frames
   task automatic stop();
      #400 drv_low = 1'b1;
      #100 scl_o = 1'b1;
      #300 drv_low = 1'b0;
      #400;
   endtask : stop
   // eight bits msb first, then the ninth clock
   task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                       output logic ack_out);
      for (int i = 7; i >= 0; i--) clk_bit(tx[i], rx[i]);
      clk_bit(ack_in, ack_out);
   endtask : xfer
endmodule : i2c_master_model

// >>> verif/test_eeprom_access.sv
// self-checking bench for the serial memory access logic
`timescale 1ns/1ps
module test_eeprom_access;
   localparam int unsigned WCYC = 200;
   // identity values are arbitrary
   localparam logic [7:0] MFR = 8'h3C;
   localparam logic [7:0] DEV_ID = 8'h19;
   localparam logic [3:0][7:0] SER = 32'h6B2E_91D4;
   logic mclk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [2:0] sel = 3'h5;
   logic scl, sda, oe, busy, a;
   logic [7:0] d;
   int n_errors = 0;
   int checks = 0;

   initial forever #50 mclk_i = ~mclk_i;

   i2c_master_model bus_u (.dut_oe_i(oe), .scl_o(scl), .sda_o(sda));
   eeprom_access #(.WRITE_CYCLES(WCYC), .MFR_CODE(MFR), .ID_FAMILY(DEV_ID[7:4]),
      .ID_DENSITY(DEV_ID[3:0]), .SERIAL_NUMBER(SER)) dut_u (
      .mclk_i(mclk_i), .rst_b_i(rst_b_i), .scl_i(scl), .sda_i(sda),
      .chip_select_bit0_i(sel[0]), .chip_select_bit1_i(sel[1]),
      .chip_select_bit2_i(sel[2]), .sda_o(), .sda_oe_o(oe), .write_busy_o(busy));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask : chk
   // nak is the expected ninth bit: 0 acknowledged, 1 not
   task automatic put(input logic [7:0] b, input logic nak, input string what);
      bus_u.xfer(b, 1'b1, d, a);
      chk(8'(a), 8'(nak), what);
   endtask : put
   task automatic probe(input logic [7:0] c, input logic nak);
      bus_u.start();
      put(c, nak, "control");
      bus_u.stop();
   endtask : probe
   task automatic addr(input logic [15:0] ad);
      bus_u.start();
      put({4'hA, sel, 1'b0}, 1'b0, "control");
      put(ad[15:8], 1'b0, "high address");
      put(ad[7:0], 1'b0, "low address");
   endtask : addr
   task automatic wr(input logic [15:0] ad, input logic [7:0] d0, input int n);
      addr(ad);
      for (int i = 0; i < n; i++) put(d0 + 8'(i), 1'b0, "data");
      bus_u.stop();
      repeat (6) @(negedge mclk_i);
      chk(8'(busy), 8'h01, "busy after stop");
      probe({4'hA, sel, 1'b0}, 1'b1);
      a = 1'b1;
      for (int i = 0; i < 60 && a !== 1'b0; i++) begin
         bus_u.start();
         bus_u.xfer({4'hA, sel, 1'b0}, 1'b1, d, a);
         bus_u.stop();
      end
      chk(8'(a), 8'h00, "poll");
      chk(8'(busy), 8'h00, "busy after poll");
   endtask : wr
   task automatic rd(input logic [15:0] ad, input logic cur, input logic [7:0] e [$]);
      if (!cur) begin
         addr(ad);
      end
      bus_u.start();
      put({4'hA, sel, 1'b1}, 1'b0, "read control");
      foreach (e[i]) begin
         bus_u.xfer(8'hFF, i == e.size() - 1, d, a);
         chk(d, e[i], "read data");
      end
      bus_u.stop();
   endtask : rd
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic s_select();
      logic [7:0] bad [3] = '{8'hA8, 8'hBA, 8'h2A};
      foreach (bad[i]) probe(bad[i], 1'b1);
      probe(8'hAA, 1'b0);
      sel = 3'h3;
      probe(8'hAA, 1'b1);
      probe(8'hA6, 1'b0);
      sel = 3'h5;
   endtask : s_select
   task automatic s_page();
      wr(16'h803E, 8'h11, 3);
      rd(16'h003E, 1'b0, '{8'h11});
      repeat (6) @(negedge mclk_i);
      chk(8'(busy), 8'h00, "address only");
      rd(16'h0000, 1'b1, '{8'h12});
      rd(16'h0000, 1'b0, '{8'h13});
   endtask : s_page
   // untouched bytes of a page must keep their old value, not stale buffer data
   task automatic s_refresh();
      wr(16'h6FFE, 8'h21, 2);
      rd(16'h6FFE, 1'b0, '{8'h21, 8'h22});
      wr(16'h0001, 8'h77, 1);
      rd(16'h003E, 1'b0, '{8'h11, 8'h12});
      rd(16'h0000, 1'b0, '{8'h13, 8'h77});
   endtask : s_refresh
   task automatic s_protect();
      wr(16'h7FFA, 8'h00, 2);
      rd(16'h7FFA, 1'b0, '{MFR, DEV_ID});
      // plain protected array byte: its content must not become the written value
      wr(16'h7000, 8'h5E, 1);
      addr(16'h7000);
      bus_u.start();
      put({4'hA, sel, 1'b1}, 1'b0, "read control");
      bus_u.xfer(8'hFF, 1'b1, d, a);
      bus_u.stop();
      checks++;
      if (d === 8'h5E) begin
         n_errors++;
         $display("ERROR %0t protected byte was written", $time);
      end
   endtask : s_protect
   task automatic s_ident();
      rd(16'h7FFA, 1'b0, '{MFR, DEV_ID, SER[3], SER[2], SER[1], SER[0], 8'h13});
   endtask : s_ident
   // ----------------------------------------------------------------
   // run control
   // ----------------------------------------------------------------
   task automatic conclude();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : conclude

   initial begin
      #3000000;
      n_errors++;
      $display("ERROR %0t run did not finish", $time);
      conclude();
   end

   initial begin
      repeat (6) @(negedge mclk_i);
      rst_b_i = 1'b1;
      repeat (4) @(negedge mclk_i);
      s_select();
      s_page();
      s_refresh();
      s_protect();
      s_ident();
      conclude();
   end
endmodule : test_eeprom_access
